// ===== design/port_status_pkg.sv
// port status page: shared constants, field layout and carrier types
// assumes a small number of cable ports selected by a port index
package port_status_pkg;
    localparam int NUM_PORTS = 3;
    localparam int PSEL_W    = 2;

    // register indices within the port page
    localparam logic [3:0] REG_SPEED   = 4'h8;
    localparam logic [3:0] REG_MODE    = 4'h9;
    localparam logic [3:0] REG_ERRCNT  = 4'ha;
    localparam logic [3:0] REG_POWER   = 4'hb;
    localparam logic [3:0] REG_DISABLE = 4'hc;
    localparam logic [3:0] REG_SELECT  = 4'hd;

    // speed codes
    localparam logic [2:0] SPD_S100  = 3'h0;
    localparam logic [2:0] SPD_S200  = 3'h1;
    localparam logic [2:0] SPD_S400  = 3'h2;
    localparam logic [2:0] SPD_S800  = 3'h3;
    localparam logic [2:0] SPD_S1600 = 3'h4;
    localparam logic [2:0] SPD_S3200 = 3'h5;
    localparam logic [2:0] SPD_MIN   = SPD_S100;

    // REG_SPEED fields
    localparam int SPD_LIMIT_LSB = 5;
    localparam int PLUG_BIT      = 4;
    localparam int CAP_LSB       = 1;
    localparam int UNREL_BIT     = 0;
    // REG_MODE fields
    localparam int BETA_BIT      = 7;
    localparam int CON_BIT       = 6;
    localparam int RECEIVE_VALID_STATUS_BIT      = 5;
    // REG_POWER fields
    localparam int SLEEP_BIT     = 7;
    localparam int SLEEPEN_BIT   = 6;
    localparam int LOOPDIS_BIT   = 5;
    localparam int STANDBY_BIT   = 4;
    // REG_DISABLE fields
    localparam int DIS_BIT       = 7;
    localparam int HARDDIS_BIT   = 6;

    localparam logic [7:0] ERR_MAX = 8'hff;

    // connection debounce
    localparam int  CLK_HZ          = 40_000_000;
    localparam int  DEBOUNCE_MS     = 341;
    localparam longint DEBOUNCE_CYC = (longint'(CLK_HZ) * DEBOUNCE_MS) / 1000;
    localparam int  DBC_W           = 24;

    // per-port line-side events and states
    typedef struct packed {
        logic       beta_only;
        logic       bilingual;
        logic [2:0] hw_speed;
        logic       new_beta_conn;
        logic       nego_fail;
        logic       sync_fail;
        logic       beta_active;
        logic       link_present;
        logic       rx_valid;
        logic       bad_codeword;
        logic       sleep_state;
        logic       loop_dis_event;
        logic       bus_reset;
        logic       standby_state;
    } line_in_s;

    typedef struct packed {
        logic [2:0] speed_limit;
        logic       sleep_permit;
        logic       tone_enable;
        logic       may_activate;
    } line_out_s;
endpackage : port_status_pkg

// ===== design/port_status_regs.sv
// port status page register bank, one field set per cable port
// assumes synchronous inputs and a single-cycle strobe register port
// Functional notes
// - speed code 000..101 means S100..S3200
// - oversize speed writes clamp to capability
// - limit used only on new beta connect; beta-only ports load it on every clock
// - bilingual port fixed at S400, writes ignored
// - reset limit is max for beta-only
// - plug present bit reads one
// - capability field reports hardware max speed
// - negotiation or sync failure sets unreliable
// - write one clears unreliable bit
// - beta bit shows beta mode activity
// - connected, receive-ok, not beta means legacy
// - error counter counts bad codewords, saturates
// - reading error counter clears it
// - sleep flag only when sleep permitted
// - strap pin loads sleep permit on the first clock after reset release
// - software sets sleep permit per port
// - loop disable set by build, cleared reset/disconnect
// - standby bit shows standby state
// - hard disable needs disable set
// - hard disabled port forces status low, no tone
// - disabled port never active, still tones
// - connected after debounce, hardware reset clears
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
module port_status_regs
    import port_status_pkg::*;
#(
    parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    // strap
    input  wire logic                 i_dormancy_strap_pin,
    // register port
    input  wire logic [3:0]           i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    // remote access read of a port error counter
    input  wire logic                 i_remote_err_rd,
    input  wire logic [PSEL_W-1:0]    i_remote_port,
    // line side
    input  wire line_in_s             i_line [NUM_PORTS],
    output line_out_s                 o_line [NUM_PORTS]
);

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } init_e;

    init_e                  init_ff;
    logic [PSEL_W-1:0]      psel_ff;
    logic [2:0]             limit_ff    [NUM_PORTS];
    logic [2:0]             applied_ff  [NUM_PORTS];
    logic                   unrel_ff    [NUM_PORTS];
    logic [7:0]             err_ff      [NUM_PORTS];
    logic                   sleepen_ff  [NUM_PORTS];
    logic                   loopdis_ff  [NUM_PORTS];
    logic                   dis_ff      [NUM_PORTS];
    logic                   harddis_ff  [NUM_PORTS];
    logic                   con_ff      [NUM_PORTS];
    logic [DBC_W-1:0]       dbc_ff      [NUM_PORTS];
    // status as software sees it, after the hard-disable override
    wire logic              con_vis     [NUM_PORTS];
    wire logic              receive_valid_status_vis    [NUM_PORTS];
    wire logic              clr_err     [NUM_PORTS];
    logic [7:0]             nxt_rdata;
    logic                   sel_ok;

    function automatic logic [2:0] clamp_speed(input logic [2:0] req,
                                               input logic [2:0] cap);
        clamp_speed = (req > cap) ? cap : req;
    endfunction : clamp_speed

    function automatic logic forced_off(input logic dis, input logic hd);
        forced_off = dis & hd;
    endfunction : forced_off

    assign sel_ok = (32'(psel_ff) < NUM_PORTS);

    // strap is captured on the first clock after release, not in reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            init_ff <= ST_STRAP;
        end else begin
            unique case (init_ff)
                ST_STRAP: init_ff <= ST_RUN;
                ST_RUN:   init_ff <= ST_RUN;
                default:  init_ff <= ST_STRAP;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            psel_ff <= '0;
        end else if (i_wr && i_addr == REG_SELECT) begin
            psel_ff <= i_wdata[PSEL_W-1:0];
        end
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic wr_here;
        assign wr_here = i_wr && sel_ok && (32'(psel_ff) == p);
        assign con_vis[p]  = con_ff[p]
                             && !forced_off(dis_ff[p], harddis_ff[p]);
        assign receive_valid_status_vis[p] = i_line[p].rx_valid
                             && !forced_off(dis_ff[p], harddis_ff[p]);
        // local and remote reads both clear the count
        assign clr_err[p]  = (i_rd && i_addr == REG_ERRCNT && sel_ok
                              && 32'(psel_ff) == p)
                             || (i_remote_err_rd
                                 && 32'(i_remote_port) == p);

        // speed limit register
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                limit_ff[p] <= SPD_MIN;
            end else if (init_ff == ST_STRAP) begin
                if (i_line[p].bilingual) begin
                    limit_ff[p] <= SPD_S400;
                end else if (i_line[p].beta_only) begin
                    limit_ff[p] <= clamp_speed(i_line[p].hw_speed,
                                               i_line[p].hw_speed);
                end
            end else if (i_line[p].bilingual) begin
                limit_ff[p] <= SPD_S400;
            end else if (wr_here && i_addr == REG_SPEED) begin
                limit_ff[p] <= clamp_speed(
                    i_wdata[SPD_LIMIT_LSB +: 3],
                    i_line[p].hw_speed);
            end
        end

        // limit as seen by the line logic
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                applied_ff[p] <= SPD_MIN;
            end else if (i_line[p].new_beta_conn || i_line[p].beta_only) begin
                applied_ff[p] <= limit_ff[p];
            end
        end

        // set wins over a same-cycle clear
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                unrel_ff[p] <= 1'b0;
            end else if (i_line[p].nego_fail || i_line[p].sync_fail) begin
                unrel_ff[p] <= 1'b1;
            end else if (wr_here && i_addr == REG_SPEED
                         && i_wdata[UNREL_BIT]) begin
                unrel_ff[p] <= 1'b0;
            end
        end

        // a codeword in the clearing cycle leaves the count at one
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                err_ff[p] <= '0;
            end else if (clr_err[p]) begin
                err_ff[p] <= i_line[p].bad_codeword ? 8'h01 : 8'h00;
            end else if (i_line[p].bad_codeword && err_ff[p] != ERR_MAX) begin
                err_ff[p] <= err_ff[p] + 8'h01;
            end
        end

        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                sleepen_ff[p] <= 1'b0;
            end else if (init_ff == ST_STRAP) begin
                sleepen_ff[p] <= i_dormancy_strap_pin;
            end else if (wr_here && i_addr == REG_POWER) begin
                sleepen_ff[p] <= i_wdata[SLEEPEN_BIT];
            end
        end

        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                loopdis_ff[p] <= 1'b0;
            end else if (!i_line[p].link_present) begin
                loopdis_ff[p] <= 1'b0;
            end else if (i_line[p].loop_dis_event) begin
                // a build result in the bus reset cycle is kept
                loopdis_ff[p] <= 1'b1;
            end else if (i_line[p].bus_reset) begin
                loopdis_ff[p] <= 1'b0;
            end
        end

        // bus reset leaves disable controls alone
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                dis_ff[p]     <= 1'b0;
                harddis_ff[p] <= 1'b0;
            end else if (wr_here && i_addr == REG_DISABLE) begin
                dis_ff[p]     <= i_wdata[DIS_BIT];
                harddis_ff[p] <= i_wdata[HARDDIS_BIT];
            end
        end

        // debounce: the connection must hold steadily before con is set
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                dbc_ff[p] <= '0;
                con_ff[p] <= 1'b0;
            end else if (!i_line[p].link_present) begin
                dbc_ff[p] <= '0;
                con_ff[p] <= 1'b0;
            end else if (longint'(dbc_ff[p]) >= DEBOUNCE_CYCLES - 1) begin
                con_ff[p] <= 1'b1;
            end else begin
                dbc_ff[p] <= dbc_ff[p] + 1'b1;
            end
        end

        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                o_line[p] <= '{speed_limit: SPD_MIN, sleep_permit: 1'b0,
                               tone_enable: 1'b1, may_activate: 1'b0};
            end else begin
                o_line[p].speed_limit  <= applied_ff[p];
                o_line[p].sleep_permit <= sleepen_ff[p];
                // disabled ports still tone unless hard disabled
                o_line[p].tone_enable  <=
                    !forced_off(dis_ff[p], harddis_ff[p]);
                o_line[p].may_activate <= !dis_ff[p] && con_vis[p];
            end
        end
    end

    // read mux for the selected port; unused bits read zero
    always_comb begin
        int s;
        s = 32'(psel_ff);
        nxt_rdata = 8'h00;
        if (i_addr == REG_SELECT) begin
            nxt_rdata[PSEL_W-1:0] = psel_ff;
        end else if (sel_ok) begin
            unique case (i_addr)
                REG_SPEED: begin
                    nxt_rdata[SPD_LIMIT_LSB +: 3] = limit_ff[s];
                    nxt_rdata[PLUG_BIT]           = 1'b1;
                    nxt_rdata[CAP_LSB +: 3]       = i_line[s].hw_speed;
                    nxt_rdata[UNREL_BIT]          = unrel_ff[s];
                end
                REG_MODE: begin
                    // beta follows the visible connection, so a
                    // hard-disabled port never claims beta mode
                    nxt_rdata[BETA_BIT] = i_line[s].beta_active
                                          && con_vis[s];
                    nxt_rdata[CON_BIT]  = con_vis[s];
                    nxt_rdata[RECEIVE_VALID_STATUS_BIT] = receive_valid_status_vis[s];
                end
                REG_ERRCNT: nxt_rdata = err_ff[s];
                REG_POWER: begin
                    nxt_rdata[SLEEP_BIT]   = i_line[s].sleep_state
                                             && sleepen_ff[s];
                    nxt_rdata[SLEEPEN_BIT] = sleepen_ff[s];
                    nxt_rdata[LOOPDIS_BIT] = loopdis_ff[s];
                    nxt_rdata[STANDBY_BIT] = i_line[s].standby_state;
                end
                REG_DISABLE: begin
                    nxt_rdata[DIS_BIT]     = dis_ff[s];
                    nxt_rdata[HARDDIS_BIT] = harddis_ff[s];
                end
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? nxt_rdata : 8'h00;
        end
    end

endmodule : port_status_regs

// ===== testbench/link_master.sv
// bus master standing in for the link controller
// assumes read data is valid only in the cycle after the strobe
`timescale 1ns/10ps
module link_master (
    // bus
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [3:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // stale data must not look valid after the strobe
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        // data launched at the strobe edge is taken at the next one
        @(posedge i_clk);
        d = i_rdata;
    endtask : rd
endmodule : link_master

// ===== testbench/port_status_assertions.sv
// timing checks on the port status bank ports
// assumes the select index is written before port reads
`timescale 1ns/10ps
module port_status_assertions
    import port_status_pkg::*;
#(
    parameter longint DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    // clock, reset, strap
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_dormancy_strap_pin,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // line side
    input wire line_in_s   i_line [NUM_PORTS],
    input wire line_out_s  o_line [NUM_PORTS]
);
    logic [1:0] sel_ff;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            sel_ff <= 2'h0;
        else if (i_wr && i_addr == REG_SELECT)
            sel_ff <= i_wdata[1:0];
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_rd(logic [3:0] a, logic c);
        i_rd && i_addr == a && sel_ff != 2'h3 && c;
    endsequence
    sequence s_down;
        !i_line[sel_ff].link_present [*2];
    endsequence
    property p_unmap;
        i_rd && i_addr < REG_SPEED |=> o_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_plug;
        s_rd(REG_SPEED, 1'b1) |=> o_rdata[PLUG_BIT];
    endproperty
    a_plug: assert property (p_plug) else $error("plug bit low");
    property p_cap;
        s_rd(REG_SPEED, 1'b1)
            |=> o_rdata[3:1] == $past(i_line[sel_ff].hw_speed);
    endproperty
    a_cap: assert property (p_cap) else $error("capability wrong");
    property p_clamp;
        s_rd(REG_SPEED, 1'b1)
            |=> o_rdata[7:5] <= $past(i_line[sel_ff].hw_speed);
    endproperty
    a_clamp: assert property (p_clamp) else $error("limit too big");
    property p_bil;
        s_rd(REG_SPEED, sel_ff == 2'h0 && i_line[0].bilingual)
            |=> o_rdata[7:5] == SPD_S400;
    endproperty
    a_bil: assert property (p_bil) else $error("bilingual limit");
    property p_boot;
        $fell(i_sys_rst) && i_line[1].beta_only
            |-> ##3 o_line[1].speed_limit == $past(i_line[1].hw_speed, 3);
    endproperty
    a_boot: assert property (p_boot) else $error("reset limit");
    property p_strap;
        $fell(i_sys_rst)
            |-> ##2 o_line[2].sleep_permit == $past(i_dormancy_strap_pin, 2);
    endproperty
    a_strap: assert property (p_strap) else $error("strap lost");
    property p_discon;
        s_down ##0 s_rd(REG_MODE, 1'b1) |=> o_rdata[7:6] == 2'b00;
    endproperty
    a_discon: assert property (p_discon) else $error("con set");
    property p_sleep;
        s_rd(REG_POWER, !o_line[sel_ff].sleep_permit) |=> !o_rdata[SLEEP_BIT];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep unpermitted");
endmodule : port_status_assertions

bind port_status_regs port_status_assertions #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_dormancy_strap_pin(i_dormancy_strap_pin), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_line(i_line), .o_line(o_line));

// ===== testbench/tb_top.sv
// self-checking bench for the port status bank
// port 0 bilingual, port 1 beta-only, port 2 plain; events on port 2
`timescale 1ns/10ps
module tb_top
    import port_status_pkg::*;
;
    logic clk, rst, strap, rem_rd, wr, rd;
    logic [1:0] rem_port;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    line_in_s  ln [NUM_PORTS];
    line_out_s lo [NUM_PORTS];
    int err_count, total_checks, cycles;
    logic [31:0] seed;
    localparam logic [15:0] M_NEW = 16'h0400, M_NEG = 16'h0200,
        M_SYN = 16'h0100, M_BAD = 16'h0010, M_LOOP = 16'h0004, M_BR = 16'h0002,
        M_UP = 16'h0060, M_DOZE = 16'h0009;
    link_master lm (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    port_status_regs #(.DEBOUNCE_CYCLES(16)) dut (.i_clk(clk),
        .i_sys_rst(rst), .i_dormancy_strap_pin(strap), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_remote_err_rd(rem_rd), .i_remote_port(rem_port),
        .i_line(ln), .o_line(lo));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [2:0] clamp(input logic [2:0] v, c);
        return (v > c) ? c : v;
    endfunction : clamp
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, e);
        logic [7:0] d;
        lm.rd(a, d);
        chk(d & m, e);
    endtask : rdc
    // line outputs are registered, so look once the updates have landed
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic pulse(input logic [15:0] m, input int n);
        @(posedge clk);
        ln[2] <= ln[2] | m;
        repeat (n) @(posedge clk);
        ln[2] <= ln[2] & ~m;
    endtask : pulse
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        strap = 1'b1;
        rem_rd = 1'b0;
        rem_port = 2'h0;
        seed = 32'd84732;
        for (int p = 0; p < NUM_PORTS; p++)
            ln[p] = '0;
        ln[0].bilingual = 1'b1;
        ln[0].hw_speed = SPD_S3200;
        ln[1].beta_only = 1'b1;
        ln[1].hw_speed = SPD_S800;
        ln[2].hw_speed = SPD_S400;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        lm.wr(REG_SPEED, 8'h00);
        rdc(REG_SPEED, 8'he0, 8'h40);
        lm.wr(REG_SELECT, 8'h01);
        rdc(REG_SPEED, 8'he0, 8'h60);
        lm.wr(REG_SPEED, 8'h20);
        settle();
        chk({5'h0, lo[1].speed_limit}, 8'h01);
        lm.wr(REG_SELECT, 8'h02);
        rdc(REG_SPEED, 8'h1e, 8'h14);
        for (int c = 0; c < 8; c++) begin
            lm.wr(REG_SPEED, {c[2:0], 5'h0});
            rdc(REG_SPEED, 8'he0, {clamp(c[2:0], SPD_S400), 5'h0});
        end
        lm.wr(REG_SPEED, 8'h20);
        settle();
        chk({5'h0, lo[2].speed_limit}, 8'h00);
        pulse(M_NEW, 1);
        settle();
        chk({5'h0, lo[2].speed_limit}, 8'h01);
        pulse(M_NEG, 1);
        rdc(REG_SPEED, 8'h01, 8'h01);
        lm.wr(REG_SPEED, 8'h20);
        rdc(REG_SPEED, 8'h01, 8'h01);
        lm.wr(REG_SPEED, 8'h21);
        rdc(REG_SPEED, 8'h01, 8'h00);
        pulse(M_SYN, 1);
        rdc(REG_SPEED, 8'h01, 8'h01);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            pulse(M_BAD, seed[4:0] + 1);
            rdc(REG_ERRCNT, 8'hff, seed[4:0] + 8'h01);
        end
        rdc(REG_ERRCNT, 8'hff, 8'h00);
        pulse(M_BAD, 300);
        rdc(REG_ERRCNT, 8'hff, 8'hff);
        pulse(M_BAD, 3);
        @(posedge clk);
        rem_rd <= 1'b1;
        rem_port <= 2'h2;
        @(posedge clk);
        rem_rd <= 1'b0;
        rdc(REG_ERRCNT, 8'hff, 8'h00);
        ln[2] <= ln[2] | M_UP;
        repeat (5) @(posedge clk);
        rdc(REG_MODE, 8'he0, 8'h20);
        repeat (20) @(posedge clk);
        rdc(REG_MODE, 8'he0, 8'h60);
        ln[2].beta_active <= 1'b1;
        rdc(REG_MODE, 8'he0, 8'he0);
        lm.wr(REG_DISABLE, 8'h40);
        settle();
        chk({6'h0, lo[2].tone_enable, lo[2].may_activate}, 8'h03);
        rdc(REG_MODE, 8'h60, 8'h60);
        lm.wr(REG_DISABLE, 8'h80);
        settle();
        chk({6'h0, lo[2].tone_enable, lo[2].may_activate}, 8'h02);
        lm.wr(REG_DISABLE, 8'hc0);
        settle();
        chk({7'h0, lo[2].tone_enable}, 8'h00);
        rdc(REG_MODE, 8'h60, 8'h00);
        lm.wr(REG_DISABLE, 8'h00);
        ln[2] <= ln[2] | M_DOZE;
        rdc(REG_POWER, 8'hd0, 8'hd0);
        lm.wr(REG_POWER, 8'h00);
        settle();
        chk({7'h0, lo[2].sleep_permit}, 8'h00);
        rdc(REG_POWER, 8'h80, 8'h00);
        pulse(M_LOOP, 1);
        rdc(REG_POWER, 8'h20, 8'h20);
        pulse(M_BR, 1);
        rdc(REG_POWER, 8'h20, 8'h00);
        pulse(M_LOOP, 1);
        @(posedge clk);
        ln[2].link_present <= 1'b0;
        rdc(REG_POWER, 8'h20, 8'h00);
        rdc(REG_MODE, 8'hc0, 8'h00);
        lm.wr(REG_SELECT, 8'h01);
        rdc(REG_ERRCNT, 8'hff, 8'h00);
        rdc(4'h3, 8'hff, 8'h00);
        lm.wr(REG_SELECT, 8'h03);
        rdc(REG_SPEED, 8'hff, 8'h00);
        wrap_up();
    end
endmodule : tb_top
